// ==== src/ddac_pkg.sv ====
// Package for the dual converter two-wire slave: command codes, reset values, widths.
// Assumes a 10 MHz system clock that oversamples the bus lines.
package ddac_pkg;
   localparam int CODE_W = 10;
   localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
   localparam logic [1:0] PD_UP = 2'h0;
   localparam logic [1:0] PD_FLOAT = 2'h1;
   localparam logic [1:0] PD_1K = 2'h2;
   localparam logic [1:0] PD_100K = 2'h3;
   localparam logic [1:0] PD_RST = PD_100K;
   localparam logic [3:0] CMD_LOAD_A_UPD = 4'h0;
   localparam logic [3:0] CMD_LOAD_B_UPD = 4'h1;
   localparam logic [3:0] CMD_IN_A = 4'h4;
   localparam logic [3:0] CMD_IN_B = 4'h5;
   localparam logic [3:0] CMD_IN_A_ALL = 4'h8;
   localparam logic [3:0] CMD_IN_B_ALL = 4'h9;
   localparam logic [3:0] CMD_LOAD_ALL = 4'hc;
   localparam logic [3:0] CMD_IN_ALL = 4'hd;
   localparam logic [3:0] CMD_UPD_ALL = 4'he;
   localparam logic [3:0] CMD_EXT = 4'hf;
   localparam logic [5:0] ADDR_HI_DEF = 6'h15; // Arbitrary value.
   localparam logic [6:0] GEN_CALL = 7'h00;
   localparam logic [3:0] BIT_ACK = 4'h8;
endpackage

// ==== src/ddac_sync.sv ====
// Two-flop synchroniser for one asynchronous input level.
// Assumes nothing of the source; the output lags by two clock edges.
`timescale 1ns/1ps
module ddac_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Level in and out
   input wire logic i_d,
   output logic o_q
);
   logic meta_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b1;
         o_q <= 1'b1;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule // ddac_sync

// ==== src/ddac_regs.sv ====
// Per-channel input and converter registers with power-down selects.
// Assumes load strobes from the serial controller on the same clock.
`timescale 1ns/1ps
module ddac_regs (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Load strobes, code and power-down mode
   input wire logic [1:0] i_in_we,
   input wire logic [1:0] i_dac_we,
   input wire logic [1:0] i_xfer,
   input wire logic [1:0] i_pd_we,
   input wire logic [9:0] i_code,
   input wire logic [1:0] i_pd_mode,
   // Contents
   output logic [19:0] o_in,
   output logic [19:0] o_dac,
   output logic [3:0] o_pd
);
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         logic [9:0] in_q;
         logic [9:0] dac_q;
         logic [1:0] pd_q;
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               in_q <= ddac_pkg::CODE_RST;
               dac_q <= ddac_pkg::CODE_RST;
               pd_q <= ddac_pkg::PD_RST;
            end else begin
               // Writes only on strobes, so power-down never disturbs codes.
               if (i_in_we[g]) in_q <= i_code;
               if (i_dac_we[g]) dac_q <= i_code;
               else if (i_xfer[g]) dac_q <= in_q;
               if (i_pd_we[g]) pd_q <= i_pd_mode;
            end
         end
         assign o_in[g*10 +: 10] = in_q;
         assign o_dac[g*10 +: 10] = dac_q;
         assign o_pd[g*2 +: 2] = pd_q;
      end
   endgenerate
endmodule // ddac_regs

// ==== src/ddac_ctrl.sv ====
// Two-wire slave controller for a dual 10-bit converter.
// Assumes SCL and SDA arrive unsynchronised; the master makes every SCL pulse.
// Function
// - Address LSB follows the address-select pin level.
// - Channels load converter directly or input register only.
// - Register contents hold through any power-down mode.
// - Channel codes are unsigned straight binary 0 to 1023.
// - Reset clears converter registers and selects 100k power-down.
// - Power-down bits: 00 up, 01 float, 10 1k, 11 100k.
// - Slave only; never drives the serial clock.
// - Bytes are 8 bits MSB first plus one acknowledge pulse.
// - SDA stable while SCL high; changes then are conditions.
// - START is SDA falling, STOP SDA rising, with SCL high.
// - Repeated START keeps the bus and restarts address reception.
// - After STOP or mismatch, ignore SCL until next START.
// - STOP honoured anywhere except in the START's own SCL high.
// - Back-to-back writes accepted with or without repeated START.
// - Acknowledge matched address and data by holding SDA low ninth clock.
// - After sending a byte, release SDA and sample master acknowledge.
// - Address LSB is direction: 0 write, 1 read.
// - Registers update at SCL fall in acknowledge; aborts change nothing.
// - No general call, 7-bit addressing only.
// - Reads return channel A converter contents as two bytes; the master acknowledges the first, and the read ends after the second.
`timescale 1ns/1ps
module ddac_ctrl #(
   parameter logic [5:0] ADDR_HI = ddac_pkg::ADDR_HI_DEF
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_addr_sel,
   // Channel state and bus busy
   output logic [9:0] o_channel_a_code,
   output logic [9:0] o_channel_b_code,
   output logic [9:0] o_channel_a_input,
   output logic [9:0] o_channel_b_input,
   output logic [1:0] o_powerdown_a,
   output logic [1:0] o_powerdown_b,
   output logic o_busy
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_DATA = 3'b011,
      ST_EXT = 3'b100,
      ST_READ = 3'b101
   } ddac_state_t;

   logic scl_s, sda_s, addr_s;
   logic scl_p_q, sda_p_q;
   ddac_state_t st_q, st_d;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] cmd_q;
   logic ack_q;
   logic rd_hi_q;
   logic hi_since_start_q;
   logic [19:0] in_w, dac_w;
   logic [3:0] pd_w;

   ddac_sync u_scl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_scl), .o_q(scl_s));
   ddac_sync u_sda (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_sda), .o_q(sda_s));
   ddac_sync u_add (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_addr_sel), .o_q(addr_s));

   // Edge and condition decode on the synchronised lines.
   wire scl_rise = scl_s && !scl_p_q;
   wire scl_fall = !scl_s && scl_p_q;
   wire start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
   // A STOP in the START's own high pulse is ignored.
   wire stop_det = scl_s && scl_p_q && !sda_p_q && sda_s && hi_since_start_q;
   wire active = (st_q != ST_IDLE);
   wire byte_done = scl_fall && (bit_q == 4'h7) && !ack_q;
   wire ack_end = scl_fall && ack_q;
   wire [7:0] byte_in = {sh_q[6:0], sda_s};
   wire [6:0] my_addr = {ADDR_HI, addr_s};
   // Bitwise compare as bits arrive; a mismatch on any upper bit drops out.
   wire addr_bad = (st_q == ST_ADDR) && scl_rise && !ack_q && (bit_q < 4'h6)
                   && (sda_s != ADDR_HI[3'(5 - bit_q)]);
   // At the eighth fall the shifter already holds the whole byte.
   wire addr_ok = (sh_q[7:1] == my_addr) && (sh_q[7:1] != ddac_pkg::GEN_CALL);
   wire [3:0] cmd_code = cmd_q[7:4];
   wire [9:0] code_in = {cmd_q[3:0], sh_q[7:2]};
   wire data_commit = (st_q == ST_DATA) && ack_end;
   wire ext_commit = (st_q == ST_EXT) && ack_end;
   wire upd_commit = (st_q == ST_CMD) && ack_end && (cmd_code == ddac_pkg::CMD_UPD_ALL);

   // Command decode into load strobes, taken at the acknowledge SCL fall.
   logic [1:0] in_we, dac_we, xfer, pd_we;
   always_comb begin
      in_we = 2'b00;
      dac_we = 2'b00;
      xfer = 2'b00;
      pd_we = 2'b00;
      if (data_commit) begin
         unique case (cmd_code)
            ddac_pkg::CMD_LOAD_A_UPD: begin dac_we = 2'b01; in_we = 2'b01; xfer = 2'b10; end
            ddac_pkg::CMD_LOAD_B_UPD: begin dac_we = 2'b10; in_we = 2'b10; xfer = 2'b01; end
            ddac_pkg::CMD_IN_A: in_we = 2'b01;
            ddac_pkg::CMD_IN_B: in_we = 2'b10;
            ddac_pkg::CMD_IN_A_ALL: begin in_we = 2'b01; xfer = 2'b10; dac_we = 2'b01; end
            ddac_pkg::CMD_IN_B_ALL: begin in_we = 2'b10; xfer = 2'b01; dac_we = 2'b10; end
            ddac_pkg::CMD_LOAD_ALL: begin in_we = 2'b11; dac_we = 2'b11; end
            ddac_pkg::CMD_IN_ALL: in_we = 2'b11;
            default: ;
         endcase
      end
      if (upd_commit) xfer = 2'b11;
      if (ext_commit) pd_we = {sh_q[3], sh_q[2]};
   end

   ddac_regs u_regs (
      .i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_in_we(in_we), .i_dac_we(dac_we), .i_xfer(xfer), .i_pd_we(pd_we),
      .i_code(code_in), .i_pd_mode(sh_q[7:6]),
      .o_in(in_w), .o_dac(dac_w), .o_pd(pd_w)
   );

   // Next state at the end of each acknowledge slot.
   always_comb begin
      st_d = st_q;
      if (stop_det || addr_bad) begin
         st_d = ST_IDLE;
      end else if (start_det) begin
         st_d = ST_ADDR;
      end else if (byte_done && st_q == ST_ADDR && !addr_ok) begin
         st_d = ST_IDLE;
      end else if (ack_end) begin
         unique case (st_q)
            ST_ADDR: st_d = sh_q[0] ? ST_READ : ST_CMD;
            ST_CMD: st_d = (cmd_code == ddac_pkg::CMD_EXT && cmd_q[3:0] == 4'h0) ? ST_EXT :
                           (cmd_code == ddac_pkg::CMD_UPD_ALL) ? ST_CMD : ST_DATA;
            ST_DATA: st_d = ST_CMD;
            ST_EXT: st_d = ST_CMD;
            ST_READ: st_d = (rd_hi_q && !sda_s) ? ST_READ : ST_IDLE;
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // Read byte: high byte carries D9..D6 of channel A in its low nibble; low byte D5..D0 then two zero bits.
   wire [7:0] rd_byte = rd_hi_q ? {4'h0, dac_w[9:6]} : {dac_w[5:0], 2'b00};
   wire drive_ack = ack_q && (st_q == ST_ADDR || st_q == ST_CMD || st_q == ST_DATA ||
                              st_q == ST_EXT);
   wire drive_rd = (st_q == ST_READ) && !ack_q && !rd_byte[3'(7 - bit_q)];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         cmd_q <= 8'h00;
         ack_q <= 1'b0;
         rd_hi_q <= 1'b1;
         hi_since_start_q <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         st_q <= st_d;
         if (start_det) hi_since_start_q <= 1'b0;
         else if (scl_fall) hi_since_start_q <= 1'b1;
         if (start_det || (!active)) begin
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            rd_hi_q <= 1'b1;
         end else if (byte_done) begin
            ack_q <= 1'b1;
            bit_q <= 4'h0;
         end else if (ack_end) begin
            ack_q <= 1'b0;
            if (st_q == ST_READ) rd_hi_q <= !rd_hi_q;
         end else if (scl_fall && hi_since_start_q) begin
            // The fall that closes a START carries no bit, so it is not counted.
            bit_q <= bit_q + 4'h1;
         end
         if (scl_rise && !ack_q) sh_q <= byte_in;
         if (st_q == ST_CMD && byte_done) cmd_q <= sh_q;
         // SDA changes only in SCL low; released on every SCL fall into master slots.
         if (scl_fall || !active) begin
            o_sda_oe <= 1'b0;
         end else if (!scl_s) begin
            o_sda_oe <= drive_ack || drive_rd;
         end
      end
   end

   assign o_sda = 1'b0;
   assign o_channel_a_code = dac_w[9:0];
   assign o_channel_b_code = dac_w[19:10];
   assign o_channel_a_input = in_w[9:0];
   assign o_channel_b_input = in_w[19:10];
   assign o_powerdown_a = pd_w[1:0];
   assign o_powerdown_b = pd_w[3:2];
   assign o_busy = active;

   sequence s_ack_slot;
      scl_fall && ack_q && (st_q == ST_DATA);
   endsequence
   chk_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      stop_det |=> st_q == ST_IDLE) else $error("stop did not idle");
   chk_start_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      start_det && !stop_det |=> st_q == ST_ADDR) else $error("start not taken");
   chk_bad_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      addr_bad |=> !active) else $error("mismatch kept active");
   chk_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !active && !start_det |=> !o_sda_oe) else $error("idle drive");
   chk_data_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_ack_slot ##0 (cmd_code == ddac_pkg::CMD_LOAD_ALL) |=> o_channel_a_code == $past(code_in))
      else $error("load all missed");
   chk_in_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_ack_slot ##0 (cmd_code == ddac_pkg::CMD_IN_A) |=> $stable(o_channel_a_code))
      else $error("input-only moved output");
   chk_no_sclk: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_sda_oe |-> !scl_s || $past(o_sda_oe)) else $error("drive began in SCL high");
   chk_pd_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !data_commit && !upd_commit |=> $stable(o_channel_b_code)) else $error("code drifted");
endmodule // ddac_ctrl

// ==== verification/ddac_master.sv ====
// Behavioural two-wire bus master that stands in for the host controller.
// Assumes an open-drain SDA resolved outside; SCL idles high between frames.
`timescale 1ns/1ps
module ddac_master (
   // Clock
   input wire logic i_clk,
   // Bus
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // One SCL period is four quarters of two system clocks, 800 ns in all.
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic qtr();
      repeat (2) @(posedge i_clk);
   endtask
   // Also serves as a repeated start when entered with SCL low.
   task automatic start();
      o_sda_low <= 1'b0;
      qtr();
      o_scl <= 1'b1;
      qtr();
      o_sda_low <= 1'b1;
      qtr();
      o_scl <= 1'b0;
      qtr();
   endtask
   task automatic stop();
      o_sda_low <= 1'b1;
      qtr();
      o_scl <= 1'b1;
      qtr();
      o_sda_low <= 1'b0;
      qtr();
   endtask
   // Data changes only while SCL is low.
   task automatic bit_io(input logic b, output logic r);
      o_sda_low <= ~b;
      qtr();
      o_scl <= 1'b1;
      qtr();
      r = i_sda;
      qtr();
      o_scl <= 1'b0;
      qtr();
   endtask
   // A read ends with mack high, a not-acknowledge, before the stop.
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                       output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(mack, a);
   endtask
endmodule // ddac_master

// ==== verification/ddac_ctrl_tb_top.sv ====
// Self-checking bench for the dual converter two-wire slave controller.
// Assumes the default upper address bits and an 800 ns bus clock.
`timescale 1ns/1ps
module ddac_ctrl_tb_top;
   logic i_clk;
   logic i_rst_n;
   logic sel;
   logic scl;
   logic m_low;
   logic sda_q;
   logic oe;
   logic busy;
   logic [9:0] a_code;
   logic [9:0] b_code;
   logic [9:0] a_in;
   logic [9:0] b_in;
   logic [1:0] pd_a;
   logic [1:0] pd_b;
   int num_errors = 0;
   int checked = 0;
   wire sda = ~(m_low | oe);
   ddac_master m_u (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
   ddac_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
      .o_sda(sda_q), .o_sda_oe(oe), .i_addr_sel(sel), .o_channel_a_code(a_code),
      .o_channel_b_code(b_code), .o_channel_a_input(a_in), .o_channel_b_input(b_in),
      .o_powerdown_a(pd_a), .o_powerdown_b(pd_b), .o_busy(busy));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   function automatic logic [7:0] ad(input logic rw);
      return {ddac_pkg::ADDR_HI_DEF, sel, rw};
   endfunction
   // Sends n bytes of v from the top, each to be acknowledged by the slave.
   task automatic wr(input int n, input logic [31:0] v, input logic stp);
      logic [7:0] r;
      logic a;
      m_u.start();
      for (int i = 0; i < n; i++) begin
         m_u.xfer(v[31-8*i -: 8], 1'b1, r, a);
         chk("ack", {9'h0, a}, 10'h000);
      end
      if (stp) m_u.stop();
   endtask
   task automatic t_nak(input logic [7:0] b);
      logic [7:0] r;
      logic a;
      m_u.start();
      m_u.xfer(b, 1'b1, r, a);
      chk("addr nak", {9'h0, a}, 10'h001);
      m_u.xfer(8'h00, 1'b1, r, a);
      chk("gated nak", {9'h0, a}, 10'h001);
      chk("busy", {9'h0, busy}, 10'h000);
      m_u.stop();
   endtask
   task automatic t_write();
      wr(3, {ad(0), 8'h0f, 8'hfc, 8'h00}, 1'b1);
      chk("a_code", a_code, 10'h3ff);
      chk("a_in", a_in, 10'h3ff);
      wr(3, {ad(0), 8'h45, 8'h54, 8'h00}, 1'b1);
      chk("a_in", a_in, 10'h155);
      chk("a_code", a_code, 10'h3ff);
      wr(4, {ad(0), 8'h5a, 8'ha8, 8'he0}, 1'b1);
      chk("b_in", b_in, 10'h2aa);
      chk("a_code", a_code, 10'h155);
      chk("b_code", b_code, 10'h2aa);
      wr(3, {ad(0), 8'h10, 8'h04, 8'h00}, 1'b0);
      wr(3, {ad(0), 8'h08, 8'h00, 8'h00}, 1'b1);
      chk("a_code", a_code, 10'h200);
      chk("b_code", b_code, 10'h001);
   endtask
   task automatic t_pd();
      for (int m = 3; m >= 0; m--) begin
         wr(3, {ad(0), 8'hf0, m[1:0], 6'h04, 8'h00}, 1'b1);
         chk("pd_a", {8'h0, pd_a}, m[9:0]);
         chk("pd_b", {8'h0, pd_b}, 10'h003);
         chk("a_code", a_code, 10'h200);
      end
      wr(3, {ad(0), 8'hf0, 8'h08, 8'h00}, 1'b1);
      chk("pd_b", {8'h0, pd_b}, 10'h000);
      chk("b_in", b_in, 10'h001);
   endtask
   task automatic t_read();
      logic [7:0] r;
      logic a;
      for (int k = 0; k < 2; k++) begin
         wr(1, {ad(1), 24'h0}, 1'b0);
         m_u.xfer(8'hff, 1'b0, r, a);
         chk("rd hi", {2'h0, r}, 10'h008);
         m_u.xfer(8'hff, 1'b1, r, a);
         chk("rd lo", {2'h0, r}, 10'h000);
      end
      m_u.stop();
   endtask
   task automatic t_abort();
      logic r;
      wr(2, {ad(0), 8'h0f, 16'h0}, 1'b0);
      for (int i = 0; i < 3; i++) m_u.bit_io(1'b1, r);
      m_u.stop();
      chk("a_code", a_code, 10'h200);
      chk("a_in", a_in, 10'h200);
   endtask
   initial begin
      i_rst_n = 1'b0;
      sel = 1'b0;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk("a_code", a_code, 10'h000);
      chk("b_code", b_code, 10'h000);
      chk("pd_a", {8'h0, pd_a}, 10'h003);
      chk("pd_b", {8'h0, pd_b}, 10'h003);
      t_write();
      t_pd();
      t_read();
      t_abort();
      t_nak({~ddac_pkg::ADDR_HI_DEF[5], ddac_pkg::ADDR_HI_DEF[4:0], 2'h0});
      t_nak(8'h00);
      sel <= 1'b1;
      repeat (4) @(posedge i_clk);
      t_nak({ddac_pkg::ADDR_HI_DEF, 2'h0});
      wr(1, {ad(0), 24'h0}, 1'b1);
      summarize();
   end
   // The tests need about 3,600 clocks; this limit leaves ample margin.
   initial begin
      repeat (40000) @(posedge i_clk);
      num_errors++;
      summarize();
   end
endmodule // ddac_ctrl_tb_top
